// file: design/i2cst_pkg.sv
package i2cst_pkg;
  localparam int          CLK_HZ          = 40000000;
  localparam int          SCL_MAX_KHZ     = 400;
  localparam logic [7:0]  ADDR_CFG_RESET  = 8'h84;
  localparam logic [7:0]  REG_RSVD_LAST   = 8'hFC;
  localparam logic [7:0]  REG_COUNT_HI    = 8'hFD;
  localparam logic [7:0]  REG_COUNT_LO    = 8'hFE;
  localparam logic [7:0]  REG_STREAM      = 8'hFF;
  localparam logic [7:0]  PTR_RESET       = 8'hFF;
  localparam logic [7:0]  EMPTY_BYTE      = 8'hFF;
  localparam logic [7:0]  RSVD_READ       = 8'h00;
  localparam int          QUEUE_DEPTH     = 256;
  localparam int          QUEUE_AW        = 8;
  localparam int          SKID_DEPTH      = 2;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } i2cst_byte_t;
endpackage

// file: design/i2cst_target.sv
`timescale 1ns/100ps
module i2cst_target (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sel_open_i,
  input  wire logic [7:0] addr_cfg_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_b_o,
  input  wire logic       msg_valid_i,
  input  wire logic [7:0] msg_data_i,
  input  wire logic       msg_last_i,
  output logic            msg_ready_o,
  output logic            msg_drop_o,
  output logic            rx_valid_o,
  output logic [7:0]      rx_data_o,
  input  wire logic       rx_ready_i,
  output logic            rx_overrun_o
);
  localparam int QUEUE_DEPTH = i2cst_pkg::QUEUE_DEPTH;
  localparam int QUEUE_AW    = i2cst_pkg::QUEUE_AW;
  // pins cross into the clock domain through two flops each
  logic [1:0] scl_sync_q, sda_sync_q, sel_sync_q;
  logic       scl_q, sda_q;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      sel_sync_q <= 2'h0;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      sel_sync_q <= {sel_sync_q[0], sel_open_i};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
    end
  end
  wire logic scl_s   = scl_sync_q[1];
  wire logic sda_s   = sda_sync_q[1];
  wire logic enable  = sel_sync_q[1];
  // at 40 MHz a 400 kHz SCL gives 100 samples per bit, ample for filtering by sync
  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_c  = scl_s & scl_q & ~sda_s & sda_q;
  wire logic stop_c   = scl_s & scl_q & sda_s & ~sda_q;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WR   = 5'h04,
    ST_RD   = 5'h08,
    ST_RACK = 5'h10
  } i2cst_state_t;

  i2cst_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic       ack_phase_q;
  logic       rw_q;
  logic [7:0] ptr_q;
  logic [7:0] wr_cnt_q;
  logic [7:0] first_byte_q;
  logic [7:0] tx_q;

  // message queue with a two-entry skid stage on its input
  logic [7:0]          mem [QUEUE_DEPTH];
  logic [QUEUE_AW:0]   wp_q, rp_q;
  logic [QUEUE_AW:0]   count;
  logic                q_full, q_empty;
  i2cst_pkg::i2cst_byte_t skid_q [i2cst_pkg::SKID_DEPTH];
  logic                drop_msg_q;
  assign count   = wp_q - rp_q;
  assign q_full  = count[QUEUE_AW];
  assign q_empty = (count == '0);

  function automatic logic [7:0] rd_mux(input logic [7:0] idx, input logic [QUEUE_AW:0] cnt,
                                        input logic emp, input logic [7:0] head);
    case (idx) // full 8-bit index space
      i2cst_pkg::REG_COUNT_HI: rd_mux = {7'h00, cnt[QUEUE_AW]};
      i2cst_pkg::REG_COUNT_LO: rd_mux = cnt[7:0];
      i2cst_pkg::REG_STREAM:   rd_mux = emp ? i2cst_pkg::EMPTY_BYTE : head;
      default:                 rd_mux = i2cst_pkg::RSVD_READ;
    endcase
  endfunction

  wire logic [7:0] head     = mem[rp_q[QUEUE_AW-1:0]];
  wire logic       addr_hit = (shift_q[7:1] == addr_cfg_i[7:1]);
  // byte completes on the eighth SCL rise
  wire logic       byte_done = scl_rise & ~ack_phase_q & (bit_q == 3'h7);
  wire logic [7:0] byte_in   = {shift_q[6:0], sda_s};
  logic            pop;

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q     <= ST_IDLE;
      bit_q       <= 3'h0;
      shift_q     <= 8'h00;
      ack_phase_q <= 1'b0;
      rw_q        <= 1'b0;
      sda_o       <= 1'b1;
      sda_oe_b_o  <= 1'b1;
    end else if (!enable || stop_c) begin
      state_q     <= ST_IDLE;
      ack_phase_q <= 1'b0;
      sda_oe_b_o  <= 1'b1;
      sda_o       <= 1'b1;
    end else if (start_c) begin
      state_q     <= ST_ADDR; // repeated start re-enters here
      bit_q       <= 3'h0;
      ack_phase_q <= 1'b0;
      sda_oe_b_o  <= 1'b1;
    end else begin
      if (scl_rise && !ack_phase_q) begin
        shift_q <= byte_in;
        bit_q   <= bit_q + 3'h1;
      end
      case (state_q)
        ST_IDLE: begin
          sda_oe_b_o <= 1'b1;
        end
        ST_ADDR, ST_WR: begin
          if (byte_done && state_q == ST_ADDR) begin
            rw_q <= byte_in[0];
            if (byte_in[7:1] == addr_cfg_i[7:1]) begin
              ack_phase_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end else if (byte_done) begin
            ack_phase_q <= 1'b1;
          end
          if (ack_phase_q && scl_fall && sda_oe_b_o) begin
            sda_o      <= 1'b0;
            sda_oe_b_o <= 1'b0; // ack low
          end else if (ack_phase_q && scl_fall) begin
            sda_oe_b_o  <= 1'b1;
            ack_phase_q <= 1'b0;
            bit_q       <= 3'h0;
            if (state_q == ST_ADDR) begin
              state_q <= rw_q ? ST_RD : ST_WR;
              if (rw_q) begin
                sda_o      <= tx_q[7];
                sda_oe_b_o <= tx_q[7];
              end
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_q == 3'h0 && ack_phase_q == 1'b0 && !sda_oe_b_o && 1'b0) begin
              sda_o <= 1'b0;
            end else if (bit_q == 3'h0) begin
              sda_o      <= 1'b1;
              sda_oe_b_o <= 1'b1;
              state_q    <= ST_RACK;
            end else begin
              sda_o      <= tx_q[3'h7 - bit_q];
              sda_oe_b_o <= tx_q[3'h7 - bit_q];
            end
          end
        end
        ST_RACK: begin
          // the ack clock is not a data bit, so the bit counter restarts here
          if (scl_rise) begin
            bit_q <= 3'h0;
            if (sda_s) begin
              state_q <= ST_IDLE; // nack ends the read
            end
          end
          if (scl_fall) begin
            sda_o      <= tx_q[7];
            sda_oe_b_o <= tx_q[7];
            state_q    <= ST_RD;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // read pointer and prefetched transmit byte
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ptr_q        <= i2cst_pkg::PTR_RESET;
      wr_cnt_q     <= 8'h00;
      first_byte_q <= 8'h00;
      tx_q         <= i2cst_pkg::EMPTY_BYTE;
      pop          <= 1'b0;
    end else begin
      pop <= 1'b0;
      if (state_q == ST_ADDR && byte_done) begin
        wr_cnt_q <= 8'h00;
        tx_q     <= rd_mux(ptr_q, count, q_empty, head);
      end
      if (state_q == ST_WR && byte_done) begin
        if (wr_cnt_q != 8'hFF) begin
          wr_cnt_q <= wr_cnt_q + 8'h01;
        end
        if (wr_cnt_q == 8'h00) begin
          first_byte_q <= byte_in;
        end
      end
      // one data byte then stop or restart selects the register
      if (state_q == ST_WR && (stop_c || start_c) && wr_cnt_q == 8'h01) begin
        ptr_q    <= first_byte_q;
        wr_cnt_q <= 8'h00;
      end
      if (state_q == ST_RD && scl_fall && bit_q == 3'h0) begin
        pop <= (ptr_q == i2cst_pkg::REG_STREAM) && !q_empty;
        if (ptr_q != i2cst_pkg::REG_STREAM) begin
          ptr_q <= ptr_q + 8'h01;
        end
      end
      if (state_q == ST_RACK && scl_rise) begin
        tx_q <= rd_mux(ptr_q, count, q_empty, head);
      end
    end
  end

  // host message bytes go to the parser, never to registers
  // first byte is held back until a second proves it is a message
  logic [1:0] rx_n_q;
  logic [7:0] rx_buf_q [2];
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_valid_o   <= 1'b0;
      rx_data_o    <= 8'h00;
      rx_overrun_o <= 1'b0;
      rx_n_q       <= 2'h0;
      rx_buf_q[0]  <= 8'h00;
      rx_buf_q[1]  <= 8'h00;
    end else begin
      rx_overrun_o <= 1'b0;
      if (rx_valid_o && rx_ready_i) begin
        rx_valid_o <= 1'b0;
      end
      if (state_q == ST_WR && byte_done && wr_cnt_q == 8'h01) begin
        // second byte proves a message: release the held first byte with it
        if (rx_n_q != 2'h0) begin
          rx_overrun_o <= 1'b1;
        end else begin
          rx_buf_q[0] <= first_byte_q;
          rx_buf_q[1] <= byte_in;
          rx_n_q      <= 2'h2;
        end
      end else if (state_q == ST_WR && byte_done && wr_cnt_q != 8'h00) begin
        if (rx_n_q == 2'h2) begin
          rx_overrun_o <= 1'b1;
        end else begin
          rx_buf_q[rx_n_q[0]] <= byte_in;
          rx_n_q              <= rx_n_q + 2'h1;
        end
      end else if (rx_n_q != 2'h0 && (!rx_valid_o || rx_ready_i)) begin
        rx_valid_o  <= 1'b1;
        rx_data_o   <= rx_buf_q[0];
        rx_buf_q[0] <= rx_buf_q[1];
        rx_n_q      <= rx_n_q - 2'h1;
      end
    end
  end

  // message input: skid stage then queue; a message that meets a full queue is
  // dropped to its end so queued bytes are never overwritten
  wire logic skid_room = !skid_q[1].valid;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      skid_q[0]   <= '0;
      skid_q[1]   <= '0;
      wp_q        <= '0;
      rp_q        <= '0;
      drop_msg_q  <= 1'b0;
      msg_ready_o <= 1'b0;
      msg_drop_o  <= 1'b0;
    end else begin
      msg_ready_o <= skid_room;
      msg_drop_o  <= 1'b0;
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (skid_q[0].valid && !q_full) begin
        mem[wp_q[QUEUE_AW-1:0]] <= skid_q[0].data;
        wp_q      <= wp_q + 1'b1;
        skid_q[0] <= skid_q[1];
        skid_q[1] <= '0;
      end
      if (msg_valid_i && msg_ready_o) begin
        if (drop_msg_q || q_full) begin
          drop_msg_q <= !msg_last_i;
          msg_drop_o <= msg_last_i;
        end else if (!skid_q[0].valid || (skid_q[0].valid && !q_full && !skid_q[1].valid)) begin
          if (skid_q[0].valid && !q_full) begin
            skid_q[0] <= '{valid: 1'b1, data: msg_data_i};
          end else if (!skid_q[0].valid) begin
            skid_q[0] <= '{valid: 1'b1, data: msg_data_i};
          end else begin
            skid_q[1] <= '{valid: 1'b1, data: msg_data_i};
          end
        end else begin
          skid_q[1] <= '{valid: 1'b1, data: msg_data_i};
        end
      end
    end
  end
endmodule

// file: tb/i2cst_host.sv
`timescale 1ns/100ps
module i2cst_host (
  input  wire logic ref_clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // four quarters of 25 clocks give a 400 kHz bit
  task automatic gap();
    repeat (25) @(posedge ref_clk_i);
  endtask
  // sda only moves while scl is low, except l2 which makes start or stop
  task automatic seq(input logic l1, input logic l2, output logic r);
    scl_o <= 1'b0;
    gap();
    sda_low_o <= l1;
    gap();
    scl_o <= 1'b1;
    gap();
    r = sda_i;
    sda_low_o <= l2;
    gap();
  endtask
  task automatic start();
    logic r;
    seq(1'b0, 1'b1, r);
  endtask
  task automatic stop();
    logic r;
    seq(1'b1, 1'b0, r);
  endtask
  task automatic xfer(input logic [7:0] d, input logic ha, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) seq(!d[i], !d[i], r[i]);
    seq(!ha, !ha, a);
  endtask
endmodule

// file: tb/i2cst_target_asserts.sv
`timescale 1ns/100ps
module i2cst_target_asserts (
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic       sel_open_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_b_o,
  input wire logic       rx_valid_o,
  input wire logic [7:0] rx_data_o,
  input wire logic       rx_ready_i,
  input wire logic       rx_overrun_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence scl_held;
    scl_i && $past(scl_i);
  endsequence
  sequence sel_closed;
    !sel_open_i [*4];
  endsequence
  sequence rx_stall;
    rx_valid_o && !rx_ready_i;
  endsequence
  AST_OE_STABLE: assert property (scl_held |-> $stable(sda_oe_b_o))
    else $error("sda enable moved while scl high");
  AST_SDA_STABLE: assert property (scl_held ##0 !sda_oe_b_o |-> $stable(sda_o))
    else $error("sda data moved while scl high");
  AST_SEL_QUIET: assert property (sel_closed |-> sda_oe_b_o)
    else $error("sda driven while select closed");
  AST_DRIVE_START: assert property ($fell(sda_oe_b_o) |-> !scl_i)
    else $error("sda drive began with scl high");
  AST_DRIVE_END: assert property ($rose(sda_oe_b_o) |-> !scl_i)
    else $error("sda release with scl high");
  AST_RX_VALID_HOLD: assert property (rx_stall |=> rx_valid_o)
    else $error("rx valid dropped while stalled");
  AST_RX_DATA_HOLD: assert property (rx_stall |=> $stable(rx_data_o))
    else $error("rx data changed while stalled");
  AST_OVERRUN: assert property (rx_overrun_o |-> $past(rx_valid_o && !rx_ready_i))
    else $error("overrun without a stalled parser");
endmodule
bind i2cst_target i2cst_target_asserts i_chk (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sel_open_i(sel_open_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_b_o(sda_oe_b_o), .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o), .rx_ready_i(rx_ready_i),
  .rx_overrun_o(rx_overrun_o)
);

// file: tb/i2cst_target_tb_top.sv
`timescale 1ns/100ps
module i2cst_target_tb_top;
  localparam logic [7:0] WA = {i2cst_pkg::ADDR_CFG_RESET[7:1], 1'b0};
  localparam logic [7:0] RA = WA | 8'h01;
  logic       ref_clk_i   = 1'b0;
  logic       rst_b_i     = 1'b0;
  logic       sel_open_i  = 1'b1;
  logic       msg_valid_i = 1'b0;
  logic [7:0] msg_data_i  = 8'h00;
  logic       msg_last_i  = 1'b0;
  logic       rx_ready_i  = 1'b1;
  logic       scl, sda_low, sda_o, sda_oe_b_o, msg_ready_o, rx_valid_o;
  logic [7:0] rx_data_o;
  logic [7:0] rxq [$];
  int         n_mismatch  = 0;
  int         compares    = 0;
  // pull-up: the wire is low only where someone drives it low
  wire        sda = !(sda_low || (!sda_oe_b_o && !sda_o));
  i2cst_target i_dut (
    .ref_clk_i   (ref_clk_i),
    .rst_b_i     (rst_b_i),
    .sel_open_i  (sel_open_i),
    .addr_cfg_i  (i2cst_pkg::ADDR_CFG_RESET), // one target, address unique on the bus
    .scl_i       (scl),
    .sda_i       (sda),
    .sda_o       (sda_o),
    .sda_oe_b_o  (sda_oe_b_o),
    .msg_valid_i (msg_valid_i),
    .msg_data_i  (msg_data_i),
    .msg_last_i  (msg_last_i),
    .msg_ready_o (msg_ready_o),
    .msg_drop_o  (),
    .rx_valid_o  (rx_valid_o),
    .rx_data_o   (rx_data_o),
    .rx_ready_i  (rx_ready_i),
    .rx_overrun_o()
  );
  i2cst_host i_host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) if (rx_valid_o === 1'b1 && rx_ready_i) rxq.push_back(rx_data_o);
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic frame_wr(input logic [7:0] ad, input logic ea, input int n, input logic [7:0] d [2]);
    logic [7:0] r;
    logic       a;
    i_host.start();
    i_host.xfer(ad, 1'b1, r, a);
    chk({7'h00, a}, {7'h00, ea});
    for (int i = 0; i < n; i++) begin
      i_host.xfer(d[i], 1'b1, r, a);
      chk({7'h00, a}, 8'h00);
    end
    i_host.stop();
  endtask
  task automatic frame_rd(input logic ix, input logic [7:0] id, input int n, input logic [7:0] e [3]);
    logic [7:0] r;
    logic       a;
    if (ix) begin
      i_host.start();
      i_host.xfer(WA, 1'b1, r, a);
      i_host.xfer(id, 1'b1, r, a);
      chk({7'h00, a}, 8'h00);
    end
    i_host.start();
    i_host.xfer(RA, 1'b1, r, a);
    chk({7'h00, a}, 8'h00);
    for (int i = 0; i < n; i++) begin
      i_host.xfer(8'hFF, i == n - 1, r, a);
      chk(r, e[i]);
    end
    i_host.stop();
  endtask
  initial begin
    int k;
    repeat (16) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    frame_rd(1'b0, 8'h00, 1, '{i2cst_pkg::EMPTY_BYTE, 8'h00, 8'h00});
    msg_valid_i <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      msg_data_i <= 8'hA1 + 8'(i);
      msg_last_i <= (i == 2);
      k = 0;
      do begin
        @(posedge ref_clk_i);
        k++;
      end while (msg_ready_o !== 1'b1 && k < 99);
      if (k == 99) n_mismatch++;
    end
    msg_valid_i <= 1'b0;
    frame_rd(1'b1, i2cst_pkg::REG_COUNT_HI, 3, '{8'h00, 8'h03, 8'hA1});
    frame_rd(1'b0, 8'h00, 3, '{8'hA2, 8'hA3, i2cst_pkg::EMPTY_BYTE});
    frame_wr(WA, 1'b0, 1, '{i2cst_pkg::REG_COUNT_HI, 8'h00});
    frame_rd(1'b0, 8'h00, 2, '{8'h00, 8'h00, 8'h00});
    frame_rd(1'b1, 8'h10, 1, '{i2cst_pkg::RSVD_READ, 8'h00, 8'h00});
    rx_ready_i <= 1'b0;
    frame_wr(WA, 1'b0, 2, '{8'hB5, 8'h62});
    repeat (20) @(posedge ref_clk_i);
    rx_ready_i <= 1'b1;
    repeat (20) @(posedge ref_clk_i);
    chk(8'(rxq.size()), 8'h02);
    chk(rxq[0], 8'hB5);
    chk(rxq[1], 8'h62);
    frame_wr(WA ^ 8'h02, 1'b1, 0, '{8'h00, 8'h00});
    sel_open_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    frame_wr(WA, 1'b1, 0, '{8'h00, 8'h00});
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    n_mismatch++;
    end_of_test();
  end
endmodule
